// ### src/cmd_buffer.sv
`timescale 1ns/1ps

module cmd_buffer
  import dac_front_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic in_valid,
  output logic      in_ready,
  input  wire cmd_t in_data,
  output logic      out_valid,
  input  wire logic out_ready,
  output cmd_t      out_data
);

  cmd_t       mem_reg [2];
  cmd_t       mem_next [2];
  logic       wr_ptr_reg;
  logic       wr_ptr_next;
  logic       rd_ptr_reg;
  logic       rd_ptr_next;
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic       push;
  logic       pop;

  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  always_comb begin
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_data;
      wr_ptr_next          = ~wr_ptr_reg;
    end
    if (pop) begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    if (push && !pop) begin
      count_next = count_reg + 2'h1;
    end else if (pop && !push) begin
      count_next = count_reg - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      mem_reg    <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

endmodule : cmd_buffer

// ### src/dac_front.sv
`timescale 1ns/1ps
`include "dac_front_params.svh"

// Functional notes
// - A 16-bit shift register gathers each whole frame before acting on it.
// - The first two frame bits form the mode field: normal or three power-downs.
// - The next eight bits are the converter code; the last six are ignored.
// - A frame starts only on a high-to-low edge of frame select.
// - While frame select is low, data shifts in on each of the first sixteen serial clock falls.
// - The sixteenth falling edge takes the last bit and queues the command, which executes when load_ready accepts it.
// - Frame select rising early clears the shift register and drops the frame.
// - After reset the converter code is zero until a valid frame arrives.
// - Mode 00 normal, 01 1k to ground, 10 100k to ground, 11 open.
// - Power-down disables the amplifier; modes 01 and 10 switch the output to a network, 11 leaves it open.
// - Power-down leaves the stored converter code untouched.
// - Output counts as valid only 50 us after leaving power-down.
// - The code is plain unsigned binary, 0 to 255.
// - The code is decoded to a one-hot string tap selection.
module dac_front
  import dac_front_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         frame_sel_n,
  input  wire logic         sclk,
  input  wire logic         din,
  input  wire logic         load_ready,
  output logic [7:0]        dac_code,
  output mode_t             mode,
  output logic [255:0]      tap_sel,
  output logic              amp_enable,
  output logic              pd_1k_en,
  output logic              pd_100k_en,
  output logic              output_valid,
  output logic              frame_abort,
  output logic              frame_stall
);

  // ****************************************************************
  // Pin synchronisers and edge finders
  // ****************************************************************
  logic [2:0]   pins_s;
  logic         fs_s;
  logic         sclk_s;
  logic         din_s;
  logic         fs_prev_reg;
  logic         sclk_prev_reg;
  logic         fs_fall;
  logic         sclk_fall;

  pin_sync #(
    .WIDTH    (3)
  ) u_pin_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({frame_sel_n, sclk, din}),
    .sync_out (pins_s)
  );

  assign fs_s      = pins_s[2];
  assign sclk_s    = pins_s[1];
  assign din_s     = pins_s[0];
  assign fs_fall   = fs_prev_reg && !fs_s;
  assign sclk_fall = sclk_prev_reg && !sclk_s;

  // Edge history resets high, so a line already low at release reads as a
  // fresh fall; the wait-for-high state keeps that from starting a frame.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fs_prev_reg   <= 1'b1;
      sclk_prev_reg <= 1'b1;
    end else if (ce) begin
      fs_prev_reg   <= fs_s;
      sclk_prev_reg <= sclk_s;
    end
  end

  // ****************************************************************
  // Frame collection
  // ****************************************************************
  frame_state_t state_reg;
  frame_state_t state_next;
  logic [15:0]  shift_reg;
  logic [15:0]  shift_next;
  logic [3:0]   cnt_reg;
  logic [3:0]   cnt_next;
  logic         abort_reg;
  logic         abort_next;
  logic         buf_in_valid;
  logic         buf_in_ready;
  cmd_t         buf_in;
  logic         buf_out_valid;
  cmd_t         buf_out;

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    abort_next = 1'b0;
    unique case (state_reg)
      ST_WAIT_HIGH: begin
        if (fs_s) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (fs_fall) begin
          state_next = ST_SHIFT;
          shift_next = 16'h0000;
          cnt_next   = 4'h0;
        end
      end
      ST_SHIFT: begin
        // An early rise wins over a falling clock seen in the same sample.
        if (fs_s) begin
          state_next = ST_IDLE;
          shift_next = 16'h0000;
          cnt_next   = 4'h0;
          abort_next = 1'b1;
        end else if (sclk_fall) begin
          shift_next = {shift_reg[14:0], din_s};
          cnt_next   = cnt_reg + 4'h1;
          if (cnt_reg == `FRAME_LAST_BIT) begin
            state_next = ST_COMMIT;
          end
        end
      end
      ST_COMMIT: begin
        if (buf_in_ready) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (fs_s) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_WAIT_HIGH;
      shift_reg <= 16'h0000;
      cnt_reg   <= 4'h0;
      abort_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg   <= cnt_next;
      abort_reg <= abort_next;
    end
  end

  // The frame is held in the shift register while the buffer is full, so a
  // slow consumer delays the update rather than losing it.
  assign buf_in_valid = (state_reg == ST_COMMIT);
  assign buf_in.mode  = {shift_reg[`MODE_HI_POS], shift_reg[`MODE_LO_POS]};
  assign buf_in.code  = shift_reg[`CODE_MSB_POS:`CODE_LSB_POS];
  assign frame_abort  = abort_reg;
  assign frame_stall  = buf_in_valid && !buf_in_ready;

  cmd_buffer u_cmd_buffer (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in),
    .out_valid (buf_out_valid),
    .out_ready (load_ready),
    .out_data  (buf_out)
  );

  // ****************************************************************
  // Converter register, mode and output stage
  // ****************************************************************
  logic [7:0]   code_reg;
  logic [7:0]   code_next;
  mode_t        mode_reg;
  mode_t        mode_next;
  logic [255:0] tap_reg;
  logic [255:0] tap_next;
  logic         amp_reg;
  logic         amp_next;
  logic         pd_1k_reg;
  logic         pd_1k_next;
  logic         pd_100k_reg;
  logic         pd_100k_next;
  logic [11:0]  rec_cnt_reg;
  logic [11:0]  rec_cnt_next;
  logic         valid_reg;
  logic         valid_next;
  logic         load;

  assign load = ce && buf_out_valid && load_ready;

  always_comb begin
    code_next    = code_reg;
    mode_next    = mode_reg;
    rec_cnt_next = rec_cnt_reg;
    valid_next   = valid_reg;
    if (load) begin
      code_next = (buf_out.mode == `MODE_NORMAL) ? buf_out.code : code_reg;
      mode_next = buf_out.mode;
    end
    if (mode_next != `MODE_NORMAL) begin
      valid_next   = 1'b0;
      rec_cnt_next = 12'h000;
    end else if (mode_reg != `MODE_NORMAL) begin
      // Wake from power-down: the analog path needs time to settle.
      valid_next   = 1'b0;
      rec_cnt_next = 12'(`RECOVERY_CYCLES - 1);
    end else if (rec_cnt_reg != 12'h000) begin
      rec_cnt_next = rec_cnt_reg - 12'h001;
    end else begin
      valid_next = 1'b1;
    end
    amp_next     = (mode_next == `MODE_NORMAL);
    pd_1k_next   = (mode_next == `MODE_PD_1K);
    pd_100k_next = (mode_next == `MODE_PD_100K);
  end

  genvar t;
  generate
    for (t = 0; t < 256; t++) begin : g_tap
      assign tap_next[t] = (code_next == 8'(t));
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_reg    <= `CODE_RESET;
      mode_reg    <= `MODE_RESET;
      tap_reg     <= 256'h1;
      amp_reg     <= 1'b1;
      pd_1k_reg   <= 1'b0;
      pd_100k_reg <= 1'b0;
      rec_cnt_reg <= 12'h000;
      valid_reg   <= 1'b1;
    end else if (ce) begin
      code_reg    <= code_next;
      mode_reg    <= mode_next;
      tap_reg     <= tap_next;
      amp_reg     <= amp_next;
      pd_1k_reg   <= pd_1k_next;
      pd_100k_reg <= pd_100k_next;
      rec_cnt_reg <= rec_cnt_next;
      valid_reg   <= valid_next;
    end
  end

  assign dac_code     = code_reg;
  assign mode         = mode_reg;
  assign tap_sel      = tap_reg;
  assign amp_enable   = amp_reg;
  assign pd_1k_en     = pd_1k_reg;
  assign pd_100k_en   = pd_100k_reg;
  assign output_valid = valid_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_last_edge;
    ce && state_reg == ST_SHIFT && !fs_s && sclk_fall && cnt_reg == `FRAME_LAST_BIT;
  endsequence

  sequence s_early_rise;
    ce && state_reg == ST_SHIFT && fs_s;
  endsequence

  sequence s_wake;
    load && buf_out.mode == `MODE_NORMAL && mode_reg != `MODE_NORMAL;
  endsequence

  AST_COMMIT_ON_16TH: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_last_edge |=> state_reg == ST_COMMIT && buf_in_valid)
    else $error("Sixteenth falling edge did not commit the frame.");

  AST_ABORT_CLEARS: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_early_rise |=> shift_reg == 16'h0000 && state_reg == ST_IDLE && frame_abort)
    else $error("Early frame select rise did not abort the frame.");

  AST_SHIFT_IN: assert property (
    @(posedge clk) disable iff (!rst_n)
    ce && state_reg == ST_SHIFT && !fs_s && sclk_fall
      |=> shift_reg[0] == $past(din_s) && shift_reg[15:1] == $past(shift_reg[14:0]))
    else $error("Data bit not shifted on serial clock fall.");

  AST_IGNORE_OUTSIDE: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_reg inside {ST_DONE, ST_COMMIT, ST_WAIT_HIGH} |=> $stable(shift_reg))
    else $error("Shift register moved outside a frame.");

  AST_START_ON_FALL: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_reg == ST_IDLE && !(ce && fs_fall) |=> state_reg != ST_SHIFT)
    else $error("Frame started without a frame select fall.");

  AST_HOLD_WITHOUT_LOAD: assert property (
    @(posedge clk) disable iff (!rst_n)
    !load |=> $stable(code_reg) && $stable(mode_reg))
    else $error("Converter code or mode changed without a command.");

  AST_LOAD_VALUES: assert property (
    @(posedge clk) disable iff (!rst_n)
    load |=> code_reg == $past(buf_out.mode == `MODE_NORMAL ? buf_out.code : code_reg)
      && mode_reg == $past(buf_out.mode))
    else $error("Loaded code or mode differs from the command.");

  AST_ONE_TAP: assert property (
    @(posedge clk) disable iff (!rst_n)
    $onehot(tap_reg) && tap_reg[code_reg])
    else $error("Tap selection is not one-hot on the code.");

  AST_OUTPUT_STAGE: assert property (
    @(posedge clk) disable iff (!rst_n)
    amp_reg == (mode_reg == `MODE_NORMAL) && pd_1k_reg == (mode_reg == `MODE_PD_1K)
      && pd_100k_reg == (mode_reg == `MODE_PD_100K))
    else $error("Output stage select does not match the mode.");

  AST_RECOVERY: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_wake |=> !output_valid [*8])
    else $error("Output marked valid too soon after wake.");

  AST_RESET_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> code_reg == `CODE_RESET && tap_reg[0])
    else $error("Converter code not zero after reset.");

endmodule : dac_front

// ### src/dac_front_params.svh
`ifndef DAC_FRONT_PARAMS_SVH
`define DAC_FRONT_PARAMS_SVH

// ****************************************************************
// Frame layout
// ****************************************************************
`define FRAME_BITS        16
`define FRAME_LAST_BIT    4'hF
`define MODE_HI_POS       15
`define MODE_LO_POS       14
`define CODE_MSB_POS      13
`define CODE_LSB_POS      6

// ****************************************************************
// Mode encodings and reset values
// ****************************************************************
`define MODE_NORMAL       2'h0
`define MODE_PD_1K        2'h1
`define MODE_PD_100K      2'h2
`define MODE_PD_OPEN      2'h3
`define CODE_RESET        8'h00
`define MODE_RESET        2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ           50
`define RECOVERY_US       50
`define RECOVERY_CYCLES   (`RECOVERY_US * `CLK_MHZ)

`endif

// ### src/dac_front_pkg.sv
package dac_front_pkg;

  typedef logic [1:0] mode_t;

  typedef struct packed {
    mode_t      mode;
    logic [7:0] code;
  } cmd_t;

  typedef enum logic [2:0] {
    ST_WAIT_HIGH,
    ST_IDLE,
    ST_SHIFT,
    ST_COMMIT,
    ST_DONE
  } frame_state_t;

endpackage : dac_front_pkg

// ### src/pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // The first stage feeds only the second; nothing else may look at it.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_reg;
      logic stable_reg;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg   <= 1'b0;
          stable_reg <= 1'b0;
        end else begin
          meta_reg   <= async_in[i];
          stable_reg <= meta_reg;
        end
      end
      assign sync_out[i] = stable_reg;
    end
  endgenerate

endmodule : pin_sync

// ### verification/serial_host.sv
`timescale 1ns/1ps

// ****************************************************************
// Serial master model
// ****************************************************************
module serial_host (
  input  wire logic clk,
  output logic      frame_sel_n,
  output logic      sclk,
  output logic      din
);
  initial begin
    frame_sel_n = 1'b1;
    sclk        = 1'b1;
    din         = 1'b0;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask : ticks

  // Sends the first falls bits of word, then extra clock pulses while the frame stays low.
  // A falls count below 16 raises frame select early, which aborts the frame.
  // The clock stands still between frames, as a real master's port does.
  task automatic send(input logic [15:0] word, input int falls, input int extra);
    frame_sel_n <= 1'b0;
    ticks(4);
    for (int i = 0; i < falls + extra; i++) begin
      din  <= (i < 16) ? word[15 - i] : ~din;
      ticks(4);
      sclk <= 1'b0;
      ticks(4);
      sclk <= 1'b1;
    end
    ticks(4);
    frame_sel_n <= 1'b1;
    // The data line is undefined outside a frame, so show the opposite of the last bit.
    din         <= ~din;
    ticks(8);
  endtask : send
endmodule : serial_host

// ### verification/test_dac_front.sv
`timescale 1ns/1ps
`include "dac_front_params.svh"

module test_dac_front;
  import dac_front_pkg::*;

  // ****************************************************************
  // Clock, pins and monitors
  // ****************************************************************
  logic         clk;
  logic         rst_n;
  logic         ce;
  logic         load_ready;
  logic         frame_sel_n;
  logic         sclk;
  logic         din;
  logic [7:0]   dac_code;
  mode_t        mode;
  logic [255:0] tap_sel;
  logic         amp_enable;
  logic         pd_1k_en;
  logic         pd_100k_en;
  logic         output_valid;
  logic         frame_abort;
  logic         frame_stall;
  int           failures;
  int           samples_checked;
  int           abort_cnt;
  int           stall_cnt;
  int           low_run;
  int           wake_len;
  logic [7:0]   last_code;
  logic [7:0]   hist[$];

  initial begin
    clk        = 1'b0;
    rst_n      = 1'b0;
    ce         = 1'b1;
    load_ready = 1'b1;
    last_code  = 8'h00;
  end

  always #10 clk = ~clk;

  serial_host host (.clk(clk), .frame_sel_n(frame_sel_n), .sclk(sclk), .din(din));

  dac_front dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .frame_sel_n(frame_sel_n), .sclk(sclk), .din(din),
    .load_ready(load_ready), .dac_code(dac_code), .mode(mode), .tap_sel(tap_sel),
    .amp_enable(amp_enable), .pd_1k_en(pd_1k_en), .pd_100k_en(pd_100k_en),
    .output_valid(output_valid), .frame_abort(frame_abort), .frame_stall(frame_stall)
  );

  // The recovery run counts cycles spent in normal mode with the output not yet valid.
  always @(posedge clk) begin
    if (frame_abort === 1'b1) abort_cnt++;
    if (frame_stall === 1'b1) stall_cnt++;
    if (dac_code !== last_code) hist.push_back(dac_code);
    last_code = dac_code;
    if (output_valid === 1'b0 && mode === `MODE_NORMAL) begin
      low_run++;
    end else begin
      if (low_run > 0) wake_len = low_run;
      low_run = 0;
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [255:0] seen, input logic [255:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic check_outputs(input logic [7:0] code, input mode_t md);
    check(dac_code, code, "code");
    check(mode, md, "mode");
    check(tap_sel, 256'h1 << code, "tap");
    check(amp_enable, md == `MODE_NORMAL, "amp");
    check(pd_1k_en, md == `MODE_PD_1K, "pd 1k");
    check(pd_100k_en, md == `MODE_PD_100K, "pd 100k");
  endtask : check_outputs

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    check_outputs(`CODE_RESET, `MODE_RESET);
    check(output_valid, 1'b1, "valid after reset");
  endtask : t_reset

  task automatic t_codes();
    logic [7:0] codes[6];
    codes = '{8'h00, 8'h01, 8'h7F, 8'h80, 8'hFE, 8'hFF};
    foreach (codes[i]) begin
      host.send({`MODE_NORMAL, codes[i], 6'h3F ^ codes[i][5:0]}, 16, 0);
      check_outputs(codes[i], `MODE_NORMAL);
    end
  endtask : t_codes

  task automatic t_modes();
    int w;
    // Power-down frames carry a different code, which must not reach the register.
    for (int m = 1; m < 4; m++) begin
      host.send({m[1:0], 8'h3C, 6'h15}, 16, 0);
      check_outputs(8'hFF, m[1:0]);
      check(output_valid, 1'b0, "valid in power-down");
    end
    host.send({`MODE_NORMAL, 8'hA5, 6'h2A}, 16, 0);
    check_outputs(8'hA5, `MODE_NORMAL);
    check(output_valid, 1'b0, "valid too early");
    w = 0;
    while (w < 3000 && output_valid !== 1'b1) begin
      w++;
      @(posedge clk);
    end
    if (w == 3000) begin
      failures++;
      tally_and_finish();
    end
    host.ticks(2);
    check(output_valid, 1'b1, "valid after wake");
    check(wake_len >= `RECOVERY_CYCLES - 1 && wake_len <= `RECOVERY_CYCLES + 1, 1'b1,
          "wake length");
  endtask : t_modes

  task automatic t_abort();
    int falls[2];
    int n;
    falls = '{15, 2};
    foreach (falls[i]) begin
      n = abort_cnt;
      host.send({`MODE_PD_OPEN, 8'h3C, 6'h00}, falls[i], 0);
      check(abort_cnt - n, 1, "abort pulses");
      check_outputs(8'hA5, `MODE_NORMAL);
    end
    host.send({`MODE_NORMAL, 8'h5A, 6'h3F}, 16, 0);
    check_outputs(8'h5A, `MODE_NORMAL);
  endtask : t_abort

  task automatic t_extra();
    host.send({`MODE_NORMAL, 8'hC3, 6'h00}, 16, 5);
    check_outputs(8'hC3, `MODE_NORMAL);
    // With the clock enable low a whole frame must pass unseen.
    ce <= 1'b0;
    host.send({`MODE_NORMAL, 8'h77, 6'h00}, 16, 0);
    ce <= 1'b1;
    host.ticks(8);
    check_outputs(8'hC3, `MODE_NORMAL);
  endtask : t_extra

  task automatic t_buffer();
    int n;
    n = stall_cnt;
    load_ready <= 1'b0;
    host.send({`MODE_NORMAL, 8'h11, 6'h00}, 16, 0);
    host.send({`MODE_NORMAL, 8'h22, 6'h00}, 16, 0);
    host.send({`MODE_NORMAL, 8'h33, 6'h00}, 16, 0);
    check_outputs(8'hC3, `MODE_NORMAL);
    check(stall_cnt > n, 1'b1, "stall seen");
    load_ready <= 1'b1;
    host.ticks(20);
    check(hist.size() >= 3, 1'b1, "history");
    if (hist.size() >= 3) begin
      check({hist[$-2], hist[$-1], hist[$]}, 24'h112233, "load order");
    end
    check_outputs(8'h33, `MODE_NORMAL);
  endtask : t_buffer

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    host.ticks(5);
    t_reset();
    t_codes();
    t_modes();
    t_abort();
    t_extra();
    t_buffer();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule : test_dac_front
